// ---- dv/mid_decoder_bench.sv ----
`default_nettype none
module mid_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mid_pkg::*;
    logic clk_i, rst_i, wr_i, rd_i, restart, pc_chg, fetch, dvalid, t_rd, t_wr;
    logic [7:0] addr, t_wdata, t_data;
    logic [31:0] wdata, rdata, rv;
    logic [15:0] word;
    logic [20:0] t_addr;
    mid_dec_t dec;
    mid_dec_t dq[$];
    logic [22:0] tq[$];
    int sq[$];
    int cyc = 0;
    int error_cnt = 0;
    int checks_done = 0;

    mid_decoder mid_decoder_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .word_i(word), .pc_change_i(pc_chg),
        .fetch_o(fetch), .tbl_data_i(t_data), .tbl_addr_o(t_addr), .tbl_rd_o(t_rd),
        .tbl_wr_o(t_wr), .tbl_wdata_o(t_wdata), .dec_o(dec), .dec_valid_o(dvalid));
    mid_prog_mem mid_prog_mem_inst (.clk_i(clk_i), .rst_i(rst_i), .restart_i(restart),
        .fetch_i(fetch), .word_o(word), .pc_change_o(pc_chg));
    // Table data follows the address, so latching the wrong read shows up
    assign t_data = t_addr[7:0] ^ 8'hA5;

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Mid-cycle sampling keeps registered outputs clear of edge races
    always @(negedge clk_i) begin
        cyc++;
        if (dvalid === 1'b1) begin
            dq.push_back(dec);
            tq.push_back({t_wr, t_rd, t_addr});
            sq.push_back(cyc);
        end
        // Whole run needs well under a thousand cycles
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_i);
        addr <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata;
    endtask : rd_reg

    // Four clocks per word, then disable before another word is sampled
    task automatic run(input logic [31:0] ctrl, input logic [16:0] w [$]);
        foreach (w[i]) mid_prog_mem_inst.mem[i] = w[i];
        dq.delete();
        tq.delete();
        sq.delete();
        @(posedge clk_i);
        restart <= 1'b1;
        @(posedge clk_i);
        restart <= 1'b0;
        wr_reg(ADDR_CTRL, ctrl);
        repeat (4 * w.size()) @(posedge clk_i);
        wr_reg(ADDR_CTRL, 32'h0);
        repeat (4) @(posedge clk_i);
    endtask : run

    task automatic dchk(input int i, input mid_cls_t c, input logic [1:0] cy);
        check("class", 32'(dq[i].cls), 32'(c));
        check("cycles", 32'(dq[i].cycles), 32'(cy));
    endtask : dchk

    task automatic t_regs;
        rd_reg(8'h10);
        check("unmapped", rv, 32'h0);
        wr_reg(ADDR_STAT, 32'hFFFFFFFF);
        rd_reg(ADDR_STAT);
        check("status_rst", rv, 32'h0);
        rd_reg(ADDR_TPTR);
        check("tptr_rst", rv, 32'(TPTR_RST));
        wr_reg(ADDR_TPTR, 32'hFFFFFFFF);
        wr_reg(ADDR_TLAT, 32'hFFFFFFFF);
        rd_reg(ADDR_TPTR);
        check("tptr_width", rv, 32'h001FFFFF);
        rd_reg(ADDR_TLAT);
        check("tlat_width", rv, 32'h000000FF);
        $display("Test registers done");
    endtask : t_regs

    task automatic t_byte;
        logic [4:0] fl [4] = '{FL_ALL, FL_ALL, FL_ZN, FL_Z};
        logic [15:0] wd;
        run(32'h1, '{17'h02612, 17'h02512, 17'h01712, 17'h06B34});
        check("count", 32'(dq.size()), 32'h4);
        for (int i = 0; i < 4; i++) begin
            wd = mid_prog_mem_inst.mem[i][15:0];
            dchk(i, C_BYTE, 2'h1);
            check("op6", 32'(dq[i].op6), 32'(wd[15:10]));
            check("dest", 32'(dq[i].dest_file), 32'(wd[9]));
            check("wr_acc", 32'(dq[i].wr_acc), 32'(!wd[9]));
            check("bank", 32'(dq[i].acc_bank), 32'(wd[8]));
            check("file", 32'(dq[i].file_addr), 32'(wd[7:0]));
            check("flags", 32'(dq[i].flag_mask), 32'(fl[i]));
            if (i > 0) check("gap", 32'(sq[i] - sq[i - 1]), 32'h4);
        end
        rd_reg(ADDR_STAT);
        check("status", rv, 32'h00040000);
        $display("Test byte done");
    endtask : t_byte

    task automatic t_bit;
        logic [15:0] wd;
        run(32'h1, '{17'h08034, 17'h08634, 17'h08FFF});
        check("count", 32'(dq.size()), 32'h3);
        for (int i = 0; i < 3; i++) begin
            wd = mid_prog_mem_inst.mem[i][15:0];
            dchk(i, C_BIT, 2'h1);
            check("bit", 32'(dq[i].bit_idx), 32'(wd[11:9]));
            check("bank", 32'(dq[i].acc_bank), 32'(wd[8]));
            check("file", 32'(dq[i].file_addr), 32'(wd[7:0]));
        end
        $display("Test bit done");
    endtask : t_bit

    task automatic t_double;
        run(32'h1, '{17'h0EF56, 17'h0F123, 17'h0ED56, 17'h0F123, 17'h0C123, 17'h0F456,
            17'h0EE25, 17'h0F0AB, 17'h0F777, 17'h0EF56, 17'h02612});
        check("count", 32'(dq.size()), 32'h6);
        dchk(0, C_GOTO, 2'h2);
        check("goto_lit", 32'(dq[0].lit), 32'h12356);
        check("goto_w", 32'(dq[0].lit_w), 32'(LW_20));
        check("goto_abs", 32'(dq[0].is_abs), 32'h1);
        check("gap", 32'(sq[1] - sq[0]), 32'h8);
        dchk(1, C_CALL, 2'h2);
        check("call_fast", 32'(dq[1].fast), 32'h1);
        check("call_lit", 32'(dq[1].lit), 32'h12356);
        dchk(2, C_MOVFF, 2'h2);
        check("src12", 32'(dq[2].src12), 32'h123);
        check("dst12", 32'(dq[2].dst12), 32'h456);
        dchk(3, C_LFSR, 2'h2);
        check("fsr_sel", 32'(dq[3].fsr_sel), 32'h2);
        check("lfsr_lit", 32'(dq[3].lit), 32'h005AB);
        check("lfsr_w", 32'(dq[3].lit_w), 32'(LW_12));
        check("lone_cls", 32'(dq[4].cls), 32'(C_NOP));
        dchk(5, C_NOP, 2'h2);
        $display("Test double done");
    endtask : t_double

    task automatic t_ctrl;
        run(32'h1, '{17'h0D005, 17'h02612, 17'h0E2FE, 17'h12612, 17'h00013, 17'h00000,
            17'h00001, 17'h0EA12});
        check("count", 32'(dq.size()), 32'h8);
        dchk(0, C_REL, 2'h2);
        check("bra_off", 32'(dq[0].offset), 32'h5);
        check("bra_abs", 32'(dq[0].is_abs), 32'h0);
        check("fill_cls", 32'(dq[1].cls), 32'(C_NOP));
        check("bc_off", 32'(dq[2].offset), 32'h1FFFFE);
        check("bc_cyc", 32'(dq[2].cycles), 32'h1);
        check("null_cls", 32'(dq[3].cls), 32'(C_NOP));
        dchk(4, C_RET, 2'h2);
        check("ret_fast", 32'(dq[4].fast), 32'h1);
        check("ret_fill", 32'(dq[5].cls), 32'(C_NOP));
        check("undef", 32'(dq[6].cls), 32'(C_NOP));
        check("ext_off", 32'(dq[7].cls), 32'(C_NOP));
        run(32'h3, '{17'h0EA12});
        check("ext_on", 32'(dq[0].cls), 32'(C_EXT));
        $display("Test control done");
    endtask : t_ctrl

    task automatic t_table;
        logic [22:0] et [5] = '{23'h200010, 23'h200010, 23'h200011, 23'h200011, 23'h400011};
        wr_reg(ADDR_TPTR, 32'h10);
        run(32'h1, '{17'h00008, 17'h00009, 17'h0000A, 17'h0000B, 17'h0000C});
        check("count", 32'(dq.size()), 32'h5);
        for (int i = 0; i < 5; i++) begin
            check("tmode", 32'(dq[i].tbl_mode), i % 4);
            check("tbus", 32'(tq[i]), 32'(et[i]));
        end
        rd_reg(ADDR_TPTR);
        check("tptr_end", rv, 32'h11);
        rd_reg(ADDR_TLAT);
        check("tlat", rv, 32'hB4);
        check("tbl_wdata", 32'(t_wdata), 32'hB4);
        $display("Test table done");
    endtask : t_table

    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        restart = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        foreach (mid_prog_mem_inst.mem[i]) mid_prog_mem_inst.mem[i] = 17'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_byte();
        t_bit();
        t_double();
        t_ctrl();
        t_table();
        conclude();
    end
endmodule : mid_decoder_bench
`default_nettype wire

// ---- dv/mid_prog_mem.sv ----
`default_nettype none
module mid_prog_mem (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic restart_i,
    // Core side
    input wire logic fetch_i,
    output logic [15:0] word_o,
    output logic pc_change_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bit 16 marks a word that the core must null
    logic [16:0] mem [0:15];
    logic [3:0] idx_reg;

    // Advance on the fetch pulse, so the next word settles long before its sampling edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_reg <= 4'h0;
        end else if (restart_i) begin
            idx_reg <= 4'h0;
        end else if (fetch_i) begin
            idx_reg <= idx_reg + 4'h1;
        end
    end
    assign word_o = mem[idx_reg][15:0];
    assign pc_change_o = mem[idx_reg][16];
endmodule : mid_prog_mem
`default_nettype wire

// ---- verilog/mid_decoder.sv ----
// Decided for this implementation: the register offsets and strobed register access.
`default_nettype none
module mid_decoder (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Program memory side
    input wire logic [15:0] word_i,
    input wire logic pc_change_i,
    output logic fetch_o,
    // Table access
    input wire logic [7:0] tbl_data_i,
    output logic [20:0] tbl_addr_o,
    output logic tbl_rd_o,
    output logic tbl_wr_o,
    output logic [7:0] tbl_wdata_o,
    // Decoded instruction
    output mid_pkg::mid_dec_t dec_o,
    output logic dec_valid_o
);
    import mid_pkg::*;

    mid_state_t s_reg;
    mid_state_t s_next;
    logic ce;
    mid_dec_t d1;

    function automatic mid_dec_t nop_dec();
        mid_dec_t r;
        r = '0;
        r.cls = C_NOP;
        r.cycles = 2'd1;
        return r;
    endfunction : nop_dec

    function automatic logic [4:0] flags_of(input logic [5:0] op);
        logic [4:0] m;
        m = 5'h00;
        case (op)
            6'h01, 6'h08, 6'h09, 6'h0A: m = FL_ALL;
            6'h04, 6'h05, 6'h07: m = FL_ZN;
            6'h1A: m = FL_Z;
            default: m = 5'h00;
        endcase
        return m;
    endfunction : flags_of

    function automatic logic is_dw(input logic [15:0] w);
        return w[15:12] == OP_MOVFF || w[15:8] == OP_GOTO
            || w[15:9] == OP_CALL || w[15:6] == OP_LFSR;
    endfunction : is_dw

    function automatic mid_dec_t decode1(input logic [15:0] w, input logic ext);
        mid_dec_t r;
        r = nop_dec();
        r.op6 = w[15:10];
        r.file_addr = w[7:0];
        r.acc_bank = w[8];
        r.dest_file = w[9];
        r.bit_idx = w[11:9];
        r.lit = {12'h000, w[7:0]};
        r.lit_w = LW_8;
        if (w[15:12] == OP_SECOND) begin
            r.cls = C_NOP;
        end else if (w[15:12] == OP_REL) begin
            r.cls = C_REL;
            r.offset = {{10{w[10]}}, w[10:0]};
            r.cycles = 2'd2;
        end else if (w[15:11] == OP_BCOND) begin
            r.cls = C_REL;
            r.offset = {{13{w[7]}}, w[7:0]};
        end else if (w[15:10] == OP_EXT) begin
            r.cls = ext ? C_EXT : C_NOP;
        end else if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB) begin
            r.cls = C_BIT;
        end else if (w[15:8] == OP_CTL) begin
            if (w[7:3] == SUB_TBL) begin
                r.cls = C_TBL;
                r.tbl_mode = w[1:0];
                r.tbl_wr = w[2];
            end else if (w[7:2] == SUB_RET) begin
                r.cls = C_RET;
                r.fast = w[0];
                r.is_abs = 1'b1;
                r.cycles = 2'd2;
            end
        end else if (w[15:11] == OP_LIT || w[15:8] == OP_MOVLB) begin
            r.cls = C_LIT;
        end else if (w[15:12] <= 4'h6) begin
            r.cls = C_BYTE;
            r.wr_acc = ~w[9];
            r.flag_mask = flags_of(w[15:10]);
        end
        return r;
    endfunction : decode1

    function automatic mid_dec_t decode2(input logic [15:0] f, input logic [15:0] w);
        mid_dec_t r;
        r = nop_dec();
        r.cycles = 2'd2;
        r.op6 = f[15:10];
        if (w[15:12] == OP_SECOND) begin
            if (f[15:12] == OP_MOVFF) begin
                r.cls = C_MOVFF;
                r.src12 = f[11:0];
                r.dst12 = w[11:0];
            end else if (f[15:6] == OP_LFSR) begin
                r.cls = C_LFSR;
                r.fsr_sel = f[5:4];
                r.lit = {8'h00, f[3:0], w[7:0]};
                r.lit_w = LW_12;
            end else begin
                r.cls = (f[15:8] == OP_GOTO) ? C_GOTO : C_CALL;
                r.fast = (f[15:8] == OP_GOTO) ? 1'b0 : f[8];
                r.lit = {w[11:0], f[7:0]};
                r.lit_w = LW_20;
                r.is_abs = 1'b1;
            end
        end
        return r;
    endfunction : decode2

    assign d1 = decode1(word_i, s_reg.ext);
    assign ce = s_reg.en && s_reg.phase == PHASE_LAST;

    always_comb begin
        s_next = s_reg;
        s_next.dvalid = 1'b0;
        s_next.fetch = 1'b0;
        s_next.tbl_rd = 1'b0;
        s_next.tbl_wr = 1'b0;
        s_next.rdata = 32'h00000000;
        s_next.phase = s_reg.en ? s_reg.phase + 2'h1 : 2'h0;
        if (wr_i) begin
            case (addr_i)
                ADDR_CTRL: {s_next.ext, s_next.en} = wdata_i[1:0];
                ADDR_TPTR: s_next.tptr = wdata_i[20:0];
                ADDR_TLAT: s_next.tlat = wdata_i[7:0];
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: s_next.rdata = {30'h00000000, s_reg.ext, s_reg.en};
                ADDR_STAT: s_next.rdata = {s_reg.count, 14'h0000, s_reg.fsm};
                ADDR_TPTR: s_next.rdata = {11'h000, s_reg.tptr};
                ADDR_TLAT: s_next.rdata = {24'h000000, s_reg.tlat};
                default: s_next.rdata = 32'h00000000;
            endcase
        end
        if (ce) begin
            s_next.fetch = 1'b1;
            s_next.dvalid = 1'b1;
            if (s_reg.tpend) begin
                // Memory answers within one instruction cycle
                s_next.tlat = tbl_data_i;
                s_next.tpend = 1'b0;
            end
            case (s_reg.fsm)
                ST_RUN: begin
                    if (pc_change_i) begin
                        s_next.dec = nop_dec();
                    end else if (is_dw(word_i)) begin
                        s_next.first = word_i;
                        s_next.fsm = ST_SECOND;
                        s_next.dvalid = 1'b0;
                    end else begin
                        s_next.dec = d1;
                        if (d1.cycles == 2'd2) begin
                            s_next.fsm = ST_FILL;
                        end
                        if (d1.cls == C_TBL) begin
                            s_next.taddr = (d1.tbl_mode == TM_PREINC) ?
                                s_reg.tptr + 21'h000001 : s_reg.tptr;
                            case (d1.tbl_mode)
                                TM_POSTINC, TM_PREINC: s_next.tptr = s_reg.tptr + 21'h000001;
                                TM_POSTDEC: s_next.tptr = s_reg.tptr - 21'h000001;
                                default: s_next.tptr = s_reg.tptr;
                            endcase
                            s_next.tbl_wr = d1.tbl_wr;
                            s_next.tbl_rd = ~d1.tbl_wr;
                            s_next.tpend = ~d1.tbl_wr;
                        end
                    end
                end
                ST_SECOND: begin
                    s_next.dec = decode2(s_reg.first, word_i);
                    s_next.fsm = ST_RUN;
                end
                ST_FILL: begin
                    s_next.dec = nop_dec();
                    s_next.fsm = ST_RUN;
                end
                default: s_next.fsm = ST_RUN;
            endcase
            if (s_next.dvalid) begin
                s_next.count = s_reg.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.fsm <= ST_RUN;
            s_reg.dec.cls <= C_NOP;
            {s_reg.ext, s_reg.en} <= CTRL_RST;
            s_reg.tptr <= TPTR_RST;
            s_reg.tlat <= TLAT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_o = s_reg.rdata;
    assign fetch_o = s_reg.fetch;
    assign tbl_addr_o = s_reg.taddr;
    assign tbl_rd_o = s_reg.tbl_rd;
    assign tbl_wr_o = s_reg.tbl_wr;
    assign tbl_wdata_o = s_reg.tlat;
    assign dec_o = s_reg.dec;
    assign dec_valid_o = s_reg.dvalid;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence run_take;
        ce && s_reg.fsm == ST_RUN && !pc_change_i;
    endsequence

    sequence jump_take;
        run_take and word_i[15:12] == OP_REL;
    endsequence

    phase_four_a: assert property (ce && s_reg.en |=> (!ce)[*3] ##1 (ce || !s_reg.en))
        else $error("instruction cycle not four clocks");

    jump_fill_a: assert property (jump_take |=> dec_valid_o && dec_o.cycles == 2'd2
        ##4 dec_valid_o && dec_o.cls == C_NOP)
        else $error("jump not followed by no-op cycle");

    dw_time_a: assert property (ce && s_reg.fsm == ST_SECOND |=> dec_valid_o
        && dec_o.cycles == 2'd2 && s_reg.fsm == ST_RUN)
        else $error("double word not two cycles");

    lone_second_a: assert property (run_take and word_i[15:12] == OP_SECOND
        |=> dec_valid_o && dec_o.cls == C_NOP)
        else $error("lone second word not no-op");

    byte_fields_a: assert property (run_take and word_i[15:12] <= 4'h6
        && word_i[15:8] != OP_CTL && !is_dw(word_i) && word_i[15:11] != OP_LIT
        && word_i[15:8] != OP_MOVLB |=> dec_o.cls == C_BYTE
        && dec_o.file_addr == $past(word_i[7:0]) && dec_o.wr_acc == !$past(word_i[9])
        && dec_o.acc_bank == $past(word_i[8]))
        else $error("byte fields wrong");

    bit_index_a: assert property (run_take and word_i[15:12] == 4'h8
        |=> dec_o.cls == C_BIT && dec_o.bit_idx == $past(word_i[11:9]))
        else $error("bit index wrong");

    goto_addr_a: assert property (ce && s_reg.fsm == ST_SECOND && s_reg.first[15:8] == OP_GOTO
        && word_i[15:12] == OP_SECOND |=> dec_o.lit == {$past(word_i[11:0]),
        $past(s_reg.first[7:0])} && dec_o.lit_w == LW_20)
        else $error("goto address wrong");

    table_mode_a: assert property (run_take and word_i[15:2] == 14'h0002
        && word_i[1:0] == TM_POSTINC |=> s_reg.tptr == $past(s_reg.tptr) + 21'h000001
        && tbl_addr_o == $past(s_reg.tptr) && tbl_rd_o)
        else $error("table post-increment wrong");

    movff_fields_a: assert property (ce && s_reg.fsm == ST_SECOND
        && s_reg.first[15:12] == OP_MOVFF && word_i[15:12] == OP_SECOND
        |=> dec_o.cls == C_MOVFF && dec_o.src12 == $past(s_reg.first[11:0])
        && dec_o.dst12 == $past(word_i[11:0]))
        else $error("register move addresses wrong");

    lfsr_fields_a: assert property (ce && s_reg.fsm == ST_SECOND
        && s_reg.first[15:6] == OP_LFSR && word_i[15:12] == OP_SECOND
        |=> dec_o.cls == C_LFSR && dec_o.fsr_sel == $past(s_reg.first[5:4])
        && dec_o.lit == {8'h00, $past(s_reg.first[3:0]), $past(word_i[7:0])})
        else $error("pointer load fields wrong");

    ext_gate_a: assert property (run_take and word_i[15:10] == OP_EXT
        |=> dec_o.cls == ($past(s_reg.ext) ? C_EXT : C_NOP))
        else $error("extended set gating wrong");

    ret_fast_a: assert property (run_take and word_i[15:2] == 14'h0004
        |=> dec_o.cls == C_RET && dec_o.fast == $past(word_i[0]) && dec_o.cycles == 2'd2)
        else $error("return fast bit wrong");

    null_word_a: assert property (ce && s_reg.fsm == ST_RUN && pc_change_i
        |=> dec_valid_o && dec_o.cls == C_NOP)
        else $error("nulled word executed");

    fetch_pulse_a: assert property (ce |=> fetch_o ##1 !fetch_o)
        else $error("fetch pulse wrong");
endmodule : mid_decoder
`default_nettype wire

// ---- verilog/mid_pkg.sv ----
// Notes on behaviour
// - Single word is opcode plus operand fields
// - Four double-word forms take operands from both
// - Lone second word executes as no_operation
// - One cycle; taken test or jump adds no-op
// - Double-word forms take two instruction cycles
// - Instruction cycle equals four clock periods
// - Destination bit picks accumulator or file register
// - Access bit picks access RAM or bank
// - Three-bit field picks bit 0 to 7
// - File field is address or pointer selector
// - Register move carries two 12-bit addresses
// - Literal is 8, 12 or 20 bits
// - Table mode: none, post-inc, post-dec, pre-inc
// - Table uses 21-bit pointer, 8-bit latch
// - Fast bit selects shadow save and restore
// - Branch offset signed; call/goto/return absolute
// - Base set plus eight extended instructions
// - Arithmetic ops report their status flag mask
// - Byte format opcode 15:10, d 9, a 8, f 7:0
// - Goto/call address: 8 bits first, 12 second
`default_nettype none
package mid_pkg;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_TPTR = 8'h08;
    localparam logic [7:0] ADDR_TLAT = 8'h0C;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [20:0] TPTR_RST = 21'h000000;
    localparam logic [7:0] TLAT_RST = 8'h00;
    localparam logic [3:0] OP_MOVFF = 4'hC;
    localparam logic [3:0] OP_REL = 4'hD;
    localparam logic [3:0] OP_SECOND = 4'hF;
    localparam logic [7:0] OP_GOTO = 8'hEF;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [9:0] OP_LFSR = 10'h3B8;
    localparam logic [4:0] OP_BCOND = 5'h1C;
    localparam logic [5:0] OP_EXT = 6'h3A;
    localparam logic [7:0] OP_CTL = 8'h00;
    localparam logic [4:0] OP_LIT = 5'h01;
    localparam logic [7:0] OP_MOVLB = 8'h01;
    localparam logic [4:0] SUB_TBL = 5'h01;
    localparam logic [5:0] SUB_RET = 6'h04;
    localparam logic [4:0] FL_ALL = 5'h1F;
    localparam logic [4:0] FL_ZN = 5'h05;
    localparam logic [4:0] FL_Z = 5'h04;
    localparam logic [1:0] TM_NONE = 2'h0;
    localparam logic [1:0] TM_POSTINC = 2'h1;
    localparam logic [1:0] TM_POSTDEC = 2'h2;
    localparam logic [1:0] TM_PREINC = 2'h3;
    localparam logic [1:0] LW_8 = 2'h0;
    localparam logic [1:0] LW_12 = 2'h1;
    localparam logic [1:0] LW_20 = 2'h2;

    typedef enum logic [3:0] {
        C_NOP, C_BYTE, C_BIT, C_LIT, C_MOVFF, C_LFSR, C_GOTO, C_CALL,
        C_REL, C_TBL, C_RET, C_EXT
    } mid_cls_t;

    typedef enum logic [1:0] {ST_RUN, ST_SECOND, ST_FILL} mid_fsm_t;

    // Flag mask order: carry, digit carry, zero, overflow, negative
    typedef struct packed {
        mid_cls_t cls;
        logic [5:0] op6;
        logic dest_file;
        logic wr_acc;
        logic acc_bank;
        logic [7:0] file_addr;
        logic [2:0] bit_idx;
        logic [1:0] fsr_sel;
        logic [11:0] src12;
        logic [11:0] dst12;
        logic [19:0] lit;
        logic [1:0] lit_w;
        logic [1:0] tbl_mode;
        logic tbl_wr;
        logic fast;
        logic [20:0] offset;
        logic is_abs;
        logic [4:0] flag_mask;
        logic [1:0] cycles;
    } mid_dec_t;

    typedef struct packed {
        logic [1:0] phase;
        mid_fsm_t fsm;
        logic [15:0] first;
        mid_dec_t dec;
        logic dvalid;
        logic fetch;
        logic en;
        logic ext;
        logic [20:0] tptr;
        logic [20:0] taddr;
        logic [7:0] tlat;
        logic tpend;
        logic tbl_rd;
        logic tbl_wr;
        logic [15:0] count;
        logic [31:0] rdata;
    } mid_state_t;
endpackage : mid_pkg
`default_nettype wire
